// File: hw/sbd_defs.svh
`ifndef SBD_DEFS_SVH
`define SBD_DEFS_SVH

// Register byte offsets
`define SBD_CTRL 8'h00
`define SBD_OPCODE 8'h04
`define SBD_EXT0 8'h08
`define SBD_EXT1 8'h0C
`define SBD_PC_IN 8'h10
`define SBD_CCR_IN 8'h14
`define SBD_OPERAND 8'h18
`define SBD_BITSRC 8'h1C
`define SBD_STATUS 8'h20
`define SBD_NEXT_PC 8'h24
`define SBD_RESULT 8'h28
`define SBD_CCR_OUT 8'h2C
`define SBD_EA_INFO 8'h30

// Status fields
`define SBD_ST_BUSY 0
`define SBD_ST_DONE 1
`define SBD_ST_ILLEGAL 2
`define SBD_ST_TAKEN 3
`define SBD_ST_KIND 5:4
`define SBD_ST_EXTS 7:6

// Flag positions
`define SBD_X 4
`define SBD_N 3
`define SBD_Z 2
`define SBD_V 1
`define SBD_C 0

// Opcode patterns
`define SBD_OP_BRANCH 4'h6
`define SBD_OP_SHIFT 4'hE
`define SBD_SHIFT_MID 3'h0
`define SBD_SHIFT_SZ 2'h3
`define SBD_STATIC_PAT 10'h021
`define SBD_DYN_TOP 4'h0
`define SBD_DYN_PAT 3'h5
`define SBD_MODE_DN 3'h0
`define SBD_MODE_AN 3'h1
`define SBD_MODE_ABS 3'h7
`define SBD_DISP_WORD 8'h00
`define SBD_DISP_LONG 8'hFF

// Size codes, constants, responses
`define SBD_SZ_BYTE 2'h0
`define SBD_SZ_WORD 2'h1
`define SBD_SZ_LONG 2'h2
`define SBD_PC_STEP 32'h0000_0002
`define SBD_RESP_OKAY 2'h0
`define SBD_RESP_SLVERR 2'h2
`endif

// File: hw/sbd_pkg.sv
package sbd_pkg;
   typedef enum logic [2:0] {
      ST_IDLE, ST_DECODE, ST_FETCH_HI, ST_FETCH_LO, ST_EXEC
   } state_t;
   typedef enum logic [1:0] {
      K_NONE, K_SHIFT, K_BRANCH, K_BITCHG
   } kind_t;
   typedef enum logic [3:0] {
      cond_always = 4'h0, cond_never = 4'h1,
      cond_unsigned_higher = 4'h2, cond_unsigned_low_or_same = 4'h3,
      cond_carry_clear = 4'h4, cond_carry_set = 4'h5,
      cond_not_equal = 4'h6, cond_equal = 4'h7,
      cond_no_overflow = 4'h8, cond_overflow = 4'h9,
      cond_positive = 4'hA, cond_negative = 4'hB,
      cond_signed_ge = 4'hC, cond_signed_lt = 4'hD,
      cond_signed_gt = 4'hE, cond_signed_le = 4'hF
   } cond_t;
   typedef logic [4:0] ccr_t;
endpackage : sbd_pkg

// File: hw/cc_if.sv
`timescale 1ns/10ps
interface cc_if;
   sbd_pkg::cond_t cond;
   sbd_pkg::ccr_t ccr;
   logic taken;
   modport req (output cond, output ccr, input taken);
   modport eval (input cond, input ccr, output taken);
endinterface : cc_if

// File: hw/cond_eval.sv
`timescale 1ns/10ps
`include "sbd_defs.svh"
module cond_eval (
   cc_if.eval cc
);
   logic n;
   logic z;
   logic v;
   logic c;

   always_comb begin
      n = cc.ccr[`SBD_N];
      z = cc.ccr[`SBD_Z];
      v = cc.ccr[`SBD_V];
      c = cc.ccr[`SBD_C];
      unique case (cc.cond)
         sbd_pkg::cond_always: cc.taken = 1'b1;
         sbd_pkg::cond_never: cc.taken = 1'b0;
         sbd_pkg::cond_unsigned_higher: cc.taken = !c && !z;
         sbd_pkg::cond_unsigned_low_or_same: cc.taken = c || z;
         sbd_pkg::cond_carry_clear: cc.taken = !c;
         sbd_pkg::cond_carry_set: cc.taken = c;
         sbd_pkg::cond_not_equal: cc.taken = !z;
         sbd_pkg::cond_equal: cc.taken = z;
         sbd_pkg::cond_no_overflow: cc.taken = !v;
         sbd_pkg::cond_overflow: cc.taken = v;
         sbd_pkg::cond_positive: cc.taken = !n;
         sbd_pkg::cond_negative: cc.taken = n;
         sbd_pkg::cond_signed_ge: cc.taken = (n == v);
         sbd_pkg::cond_signed_lt: cc.taken = (n != v);
         sbd_pkg::cond_signed_gt: cc.taken = (n == v) && !z;
         sbd_pkg::cond_signed_le: cc.taken = z || (n != v);
      endcase
   end
endmodule : cond_eval

// File: hw/shift_branch_bit_change_decode.sv
`timescale 1ns/10ps
`include "sbd_defs.svh"
module shift_branch_bit_change_decode (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic exec_done,
   output logic illegal_instr,
   output logic [31:0] next_pc,
   output logic [4:0] flags_out
);
   ////////////////////////////////////////////////////////////////
   function automatic logic [31:0] merge(
      input logic [31:0] old,
      input logic [31:0] data,
      input logic [3:0] strb
   );
      logic [31:0] m;
      m = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            m[i*8 +: 8] = data[i*8 +: 8];
         end
      end
      return m;
   endfunction : merge

   function automatic logic ea_ok(
      input logic [5:0] ea,
      input logic allow_dn
   );
      logic ok;
      case (ea[5:3])
         `SBD_MODE_DN: ok = allow_dn;
         `SBD_MODE_AN: ok = 1'b0;
         `SBD_MODE_ABS: ok = (ea[2:0] == 3'h0) || (ea[2:0] == 3'h1);
         default: ok = 1'b1;
      endcase
      return ok;
   endfunction : ea_ok

   function automatic logic [31:0] sext16(input logic [15:0] w);
      return {{16{w[15]}}, w};
   endfunction : sext16

   ////////////////////////////////////////////////////////////////
   sbd_pkg::state_t state_r;
   sbd_pkg::kind_t kind;
   logic aw_held_r;
   logic w_held_r;
   logic [7:0] awaddr_r;
   logic [31:0] wdata_r;
   logic [3:0] wstrb_r;
   logic bvalid_r;
   logic [1:0] bresp_r;
   logic rvalid_r;
   logic [1:0] rresp_r;
   logic [31:0] rdata_r;
   logic wr_go;
   logic wr_cfg;
   logic start_go;
   logic [15:0] op_r;
   logic [15:0] ext0_r;
   logic [15:0] ext1_r;
   logic [31:0] pc_in_r;
   logic [4:0] ccr_in_r;
   logic [31:0] operand_r;
   logic [31:0] bitsrc_r;
   logic [31:0] disp_r;
   logic [7:0] bitnum_r;
   logic [1:0] ext_cnt_r;
   logic [31:0] result_r;
   logic done_r;
   logic taken_r;
   logic [1:0] size_r;
   logic is_static;
   logic legal;
   logic [1:0] need;
   logic [31:0] pc_base;
   logic [31:0] seq_pc;
   logic [15:0] shl;
   logic [15:0] shr;
   logic tested;
   logic [31:0] flip;

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   ////////////////////////////////////////////////////////////////
   // Write channel: address and data may arrive in either order
   assign s_axi_awready = !aw_held_r && !bvalid_r;
   assign s_axi_wready = !w_held_r && !bvalid_r;
   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;
   assign wr_go = aw_held_r && w_held_r;
   // Inputs frozen while a decode runs so results stay coherent
   assign wr_cfg = wr_go && (state_r == sbd_pkg::ST_IDLE);
   assign start_go = wr_cfg && (awaddr_r == `SBD_CTRL) && wstrb_r[0]
      && wdata_r[0];

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_r <= 1'b0;
         awaddr_r <= 8'h00;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_held_r <= 1'b1;
         awaddr_r <= {s_axi_awaddr[7:2], 2'h0};
      end else if (wr_go) begin
         aw_held_r <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_held_r <= 1'b0;
         wdata_r <= 32'h0000_0000;
         wstrb_r <= 4'h0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_held_r <= 1'b1;
         wdata_r <= s_axi_wdata;
         wstrb_r <= s_axi_wstrb;
      end else if (wr_go) begin
         w_held_r <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_r <= 1'b0;
         bresp_r <= `SBD_RESP_OKAY;
      end else if (wr_go) begin
         bvalid_r <= 1'b1;
         bresp_r <= (awaddr_r > `SBD_EA_INFO) ? `SBD_RESP_SLVERR
            : `SBD_RESP_OKAY;
      end else if (s_axi_bready) begin
         bvalid_r <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         op_r <= 16'h0000;
         ext0_r <= 16'h0000;
         ext1_r <= 16'h0000;
         pc_in_r <= 32'h0000_0000;
         ccr_in_r <= 5'h00;
         operand_r <= 32'h0000_0000;
         bitsrc_r <= 32'h0000_0000;
      end else if (wr_cfg) begin
         case (awaddr_r)
            `SBD_OPCODE: op_r <= 16'(merge({16'h0000, op_r}, wdata_r,
               wstrb_r));
            `SBD_EXT0: ext0_r <= 16'(merge({16'h0000, ext0_r}, wdata_r,
               wstrb_r));
            `SBD_EXT1: ext1_r <= 16'(merge({16'h0000, ext1_r}, wdata_r,
               wstrb_r));
            `SBD_PC_IN: pc_in_r <= merge(pc_in_r, wdata_r, wstrb_r);
            `SBD_CCR_IN: ccr_in_r <= 5'(merge({27'h0, ccr_in_r}, wdata_r,
               wstrb_r));
            `SBD_OPERAND: operand_r <= merge(operand_r, wdata_r, wstrb_r);
            `SBD_BITSRC: bitsrc_r <= merge(bitsrc_r, wdata_r, wstrb_r);
            default: ;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////
   // Read channel
   assign s_axi_arready = !rvalid_r;
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rdata = rdata_r;
   assign s_axi_rresp = rresp_r;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_r <= 1'b0;
         rresp_r <= `SBD_RESP_OKAY;
         rdata_r <= 32'h0000_0000;
      end else if (s_axi_arvalid && s_axi_arready) begin
         rvalid_r <= 1'b1;
         rresp_r <= `SBD_RESP_OKAY;
         rdata_r <= 32'h0000_0000;
         case ({s_axi_araddr[7:2], 2'h0})
            `SBD_CTRL: rdata_r <= 32'h0000_0000;
            `SBD_OPCODE: rdata_r <= {16'h0000, op_r};
            `SBD_EXT0: rdata_r <= {16'h0000, ext0_r};
            `SBD_EXT1: rdata_r <= {16'h0000, ext1_r};
            `SBD_PC_IN: rdata_r <= pc_in_r;
            `SBD_CCR_IN: rdata_r <= {27'h0, ccr_in_r};
            `SBD_OPERAND: rdata_r <= operand_r;
            `SBD_BITSRC: rdata_r <= bitsrc_r;
            `SBD_STATUS: rdata_r <= {24'h0, ext_cnt_r, kind, taken_r,
               illegal_instr, done_r, state_r != sbd_pkg::ST_IDLE};
            `SBD_NEXT_PC: rdata_r <= next_pc;
            `SBD_RESULT: rdata_r <= result_r;
            `SBD_CCR_OUT: rdata_r <= {27'h0, flags_out};
            `SBD_EA_INFO: rdata_r <= {24'h0, size_r, op_r[5:0]};
            default: rresp_r <= `SBD_RESP_SLVERR;
         endcase
      end else if (s_axi_rready) begin
         rvalid_r <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////
   // Decode of the held opcode word
   assign is_static = (op_r[15:6] == `SBD_STATIC_PAT);

   always_comb begin
      kind = sbd_pkg::K_NONE;
      if (op_r[15:12] == `SBD_OP_BRANCH) begin
         kind = sbd_pkg::K_BRANCH;
      end else if (op_r[15:12] == `SBD_OP_SHIFT && op_r[11:9] ==
            `SBD_SHIFT_MID && op_r[7:6] == `SBD_SHIFT_SZ) begin
         kind = sbd_pkg::K_SHIFT;
      end else if (is_static || (op_r[15:12] == `SBD_DYN_TOP &&
            op_r[8:6] == `SBD_DYN_PAT)) begin
         kind = sbd_pkg::K_BITCHG;
      end
   end

   always_comb begin
      unique case (kind)
         sbd_pkg::K_SHIFT: legal = ea_ok(op_r[5:0], 1'b0);
         sbd_pkg::K_BITCHG: legal = ea_ok(op_r[5:0], 1'b1);
         sbd_pkg::K_BRANCH: legal = 1'b1;
         sbd_pkg::K_NONE: legal = 1'b0;
      endcase
   end

   always_comb begin
      need = 2'h0;
      if (kind == sbd_pkg::K_BRANCH) begin
         if (op_r[7:0] == `SBD_DISP_WORD) begin
            need = 2'h1;
         end else if (op_r[7:0] == `SBD_DISP_LONG) begin
            need = 2'h2;
         end
      end else if (kind == sbd_pkg::K_BITCHG && is_static) begin
         need = 2'h1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_r <= sbd_pkg::ST_IDLE;
      end else begin
         unique case (state_r)
            sbd_pkg::ST_IDLE: if (start_go) state_r <= sbd_pkg::ST_DECODE;
            sbd_pkg::ST_DECODE: state_r <= (legal && need != 2'h0) ?
               sbd_pkg::ST_FETCH_HI : sbd_pkg::ST_EXEC;
            sbd_pkg::ST_FETCH_HI: state_r <= (need == 2'h2) ?
               sbd_pkg::ST_FETCH_LO : sbd_pkg::ST_EXEC;
            sbd_pkg::ST_FETCH_LO: state_r <= sbd_pkg::ST_EXEC;
            sbd_pkg::ST_EXEC: state_r <= sbd_pkg::ST_IDLE;
            default: state_r <= sbd_pkg::ST_IDLE;
         endcase
      end
   end

   // Extension words are consumed in stream order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         disp_r <= 32'h0000_0000;
         bitnum_r <= 8'h00;
         ext_cnt_r <= 2'h0;
      end else if (state_r == sbd_pkg::ST_DECODE) begin
         disp_r <= {{24{op_r[7]}}, op_r[7:0]};
         bitnum_r <= bitsrc_r[7:0];
         ext_cnt_r <= 2'h0;
      end else if (state_r == sbd_pkg::ST_FETCH_HI) begin
         ext_cnt_r <= 2'h1;
         bitnum_r <= ext0_r[7:0];
         if (need == 2'h2) begin
            disp_r <= {ext0_r, 16'h0000};
         end else begin
            disp_r <= sext16(ext0_r);
         end
      end else if (state_r == sbd_pkg::ST_FETCH_LO) begin
         ext_cnt_r <= 2'h2;
         disp_r <= {disp_r[31:16], ext1_r};
      end
   end

   ////////////////////////////////////////////////////////////////
   // Execution datapath
   cc_if u_cc ();
   assign u_cc.cond = sbd_pkg::cond_t'(op_r[11:8]);
   assign u_cc.ccr = ccr_in_r;
   cond_eval u_eval (
      .cc(u_cc.eval)
   );

   assign pc_base = pc_in_r + `SBD_PC_STEP;
   assign seq_pc = pc_base + {29'h0, ext_cnt_r, 1'b0};
   assign shl = {operand_r[14:0], 1'b0};
   assign shr = {operand_r[15], operand_r[15:1]};

   always_comb begin
      tested = operand_r[bitnum_r[2:0]];
      flip = {24'h0, 8'h01 << bitnum_r[2:0]};
      if (op_r[5:3] == `SBD_MODE_DN) begin
         tested = operand_r[bitnum_r[4:0]];
         flip = 32'h0000_0001 << bitnum_r[4:0];
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         result_r <= 32'h0000_0000;
         flags_out <= 5'h00;
         next_pc <= 32'h0000_0000;
         taken_r <= 1'b0;
         size_r <= `SBD_SZ_BYTE;
      end else if (state_r == sbd_pkg::ST_EXEC) begin
         result_r <= operand_r;
         flags_out <= ccr_in_r;
         next_pc <= seq_pc;
         taken_r <= 1'b0;
         size_r <= `SBD_SZ_WORD;
         if (!legal) begin
            next_pc <= pc_in_r;
         end else if (kind == sbd_pkg::K_BRANCH) begin
            taken_r <= u_cc.taken;
            if (u_cc.taken) begin
               next_pc <= pc_base + disp_r;
            end
         end else if (kind == sbd_pkg::K_SHIFT) begin
            result_r <= {16'h0000, op_r[8] ? shl : shr};
            flags_out[`SBD_X] <= op_r[8] ? operand_r[15] : operand_r[0];
            flags_out[`SBD_C] <= op_r[8] ? operand_r[15] : operand_r[0];
            flags_out[`SBD_N] <= op_r[8] ? operand_r[14] : operand_r[15];
            flags_out[`SBD_Z] <= op_r[8] ? (shl == 16'h0000)
               : (shr == 16'h0000);
            // Right shift copies the sign, so the MSB never moves
            flags_out[`SBD_V] <= op_r[8] &&
               (operand_r[15] ^ operand_r[14]);
         end else begin
            result_r <= (op_r[5:3] == `SBD_MODE_DN) ? operand_r ^ flip
               : {24'h0, operand_r[7:0] ^ flip[7:0]};
            flags_out[`SBD_Z] <= !tested;
            size_r <= (op_r[5:3] == `SBD_MODE_DN) ? `SBD_SZ_LONG
               : `SBD_SZ_BYTE;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         done_r <= 1'b0;
         exec_done <= 1'b0;
         illegal_instr <= 1'b0;
      end else begin
         exec_done <= (state_r == sbd_pkg::ST_EXEC);
         if (state_r == sbd_pkg::ST_EXEC) begin
            done_r <= 1'b1;
            illegal_instr <= !legal;
         end else if (start_go) begin
            done_r <= 1'b0;
            illegal_instr <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////
   AST_SHIFT_DIR: assert property (
      state_r == sbd_pkg::ST_EXEC && legal && kind == sbd_pkg::K_SHIFT
      |=> result_r == (op_r[8] ? {16'h0, operand_r[14:0], 1'b0}
         : {16'h0, operand_r[15], operand_r[15:1]}))
      else $error("memory shift moved the word wrongly");

   AST_SHIFT_V: assert property (
      state_r == sbd_pkg::ST_EXEC && legal && kind == sbd_pkg::K_SHIFT
      |=> flags_out[`SBD_V] == (result_r[15] != operand_r[15]))
      else $error("shift overflow flag wrong");

   AST_BR_TARGET: assert property (
      state_r == sbd_pkg::ST_EXEC && kind == sbd_pkg::K_BRANCH
      && u_cc.taken |=> next_pc == pc_in_r + 32'h2 + disp_r && taken_r)
      else $error("taken branch target wrong");

   AST_BR_FLAGS: assert property (
      state_r == sbd_pkg::ST_EXEC && kind == sbd_pkg::K_BRANCH
      |=> flags_out == ccr_in_r && result_r == operand_r)
      else $error("branch altered flags");

   AST_DISP_WORD: assert property (
      state_r == sbd_pkg::ST_DECODE && kind == sbd_pkg::K_BRANCH
      && op_r[7:0] == 8'h00 |=> state_r == sbd_pkg::ST_FETCH_HI
      ##1 state_r == sbd_pkg::ST_EXEC && disp_r == sext16(ext0_r))
      else $error("word displacement not fetched");

   AST_DISP_LONG: assert property (
      state_r == sbd_pkg::ST_DECODE && kind == sbd_pkg::K_BRANCH
      && op_r[7:0] == 8'hFF |-> ##3 state_r == sbd_pkg::ST_EXEC
      && disp_r == {ext0_r, ext1_r} && ext_cnt_r == 2'h2)
      else $error("long displacement not fetched");

   AST_TEST_AND_INVERT_BIT_ONE: assert property (
      state_r == sbd_pkg::ST_EXEC && legal && kind == sbd_pkg::K_BITCHG
      |=> $onehot(result_r ^ operand_r) || (op_r[5:3] != 3'h0
         && result_r[31:8] == 24'h0
         && $onehot(result_r[7:0] ^ operand_r[7:0])))
      else $error("bit change did not invert one bit");

   AST_TEST_AND_INVERT_BIT_Z: assert property (
      state_r == sbd_pkg::ST_EXEC && legal && kind == sbd_pkg::K_BITCHG
      |=> flags_out[`SBD_Z] == ((result_r & flip) != 32'h0)
      && flags_out[4:3] == ccr_in_r[4:3] && flags_out[1:0] == ccr_in_r[1:0])
      else $error("bit change flags wrong");

   AST_ILLEGAL: assert property (
      state_r == sbd_pkg::ST_DECODE && !legal
      |-> ##2 illegal_instr && exec_done && next_pc == pc_in_r)
      else $error("illegal encoding was executed");

   AST_FINISH: assert property (
      start_go |-> ##[3:5] exec_done)
      else $error("decode did not finish in time");
endmodule : shift_branch_bit_change_decode

// File: tb/tb_shift_branch_bit_change_decode.sv
`timescale 1ns/10ps
`include "sbd_defs.svh"
`define CHK(g, e) begin \
   tests_run++; \
   if ((g) !== (e)) begin \
      n_errors++; \
      $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); \
   end \
end
module tb_shift_branch_bit_change_decode;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, done_p, ill_p;
   logic [1:0] bresp, rresp, resp;
   logic [31:0] rdata, npc, rd_v;
   logic [4:0] fl;
   int n_errors = 0;
   int tests_run = 0;
   int n_done = 0;
   always #5 aclk = ~aclk;
   // Counts completion pulses, which stand for one cycle only
   always @(posedge aclk) if (done_p === 1'b1) n_done++;
   shift_branch_bit_change_decode dut_u (
      .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .exec_done(done_p), .illegal_instr(ill_p), .next_pc(npc), .flags_out(fl));
   ////////////////////////////////////////////////////////////////////////////
   task automatic print_verdict;
      if (n_errors == 0 && tests_run > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : print_verdict
   task automatic give_up;
      n_errors++;
      print_verdict();
   endtask : give_up
   // Handshakes sampled mid-cycle, where they equal the value at the next edge
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic ha, hw, hb;
      hb = 1'b0;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (int i = 0; i < 40 && !hb; i++) begin
         @(negedge aclk);
         ha = awvalid && awready === 1'b1;
         hw = wvalid && wready === 1'b1;
         hb = bvalid === 1'b1;
         resp = bresp;
         @(posedge aclk);
         if (ha) awvalid <= 1'b0;
         if (hw) wvalid <= 1'b0;
         if (hb) bready <= 1'b0;
      end
      if (!hb) give_up();
   endtask : wr
   task automatic rd(input logic [7:0] a);
      logic ha, hr;
      hr = 1'b0;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (int i = 0; i < 40 && !hr; i++) begin
         @(negedge aclk);
         ha = arvalid && arready === 1'b1;
         hr = rvalid === 1'b1;
         rd_v = rdata;
         resp = rresp;
         @(posedge aclk);
         if (ha) arvalid <= 1'b0;
         if (hr) rready <= 1'b0;
      end
      if (!hr) give_up();
   endtask : rd
   task automatic run(input logic [15:0] op, e0, e1, input logic [31:0] pc,
                      input logic [4:0] cc, input logic [31:0] od, bs);
      wr(`SBD_OPCODE, {16'h0, op});
      wr(`SBD_EXT0, {16'h0, e0});
      wr(`SBD_EXT1, {16'h0, e1});
      wr(`SBD_PC_IN, pc);
      wr(`SBD_CCR_IN, {27'h0, cc});
      wr(`SBD_OPERAND, od);
      wr(`SBD_BITSRC, bs);
      wr(`SBD_CTRL, 32'h1);
      rd_v = 32'h0;
      for (int i = 0; i < 20 && rd_v[`SBD_ST_DONE] !== 1'b1; i++) rd(`SBD_STATUS);
      if (rd_v[`SBD_ST_DONE] !== 1'b1) give_up();
   endtask : run
   task automatic ops(input logic [15:0] op, e0, input logic [31:0] od, bs,
                      input logic [4:0] cc, input logic [31:0] er, input logic [4:0] ef,
                      input logic ei);
      int d0;
      d0 = n_done;
      run(op, e0, 16'h0, 32'h400, cc, od, bs);
      `CHK(rd_v[`SBD_ST_ILLEGAL], ei)
      `CHK(ill_p, ei)
      `CHK(n_done, d0 + 1)
      `CHK(fl, ef)
      rd(`SBD_RESULT);
      `CHK(rd_v, er)
   endtask : ops
   // Flags are {N,Z,V,C}; table index is the condition code
   function automatic logic cond_ok(input logic [3:0] c, input logic [3:0] f);
      logic [15:0] t;
      t = {f[2] | (f[3] ^ f[1]), !f[2] & !(f[3] ^ f[1]), f[3] ^ f[1], !(f[3] ^ f[1]),
           f[3], !f[3], f[1], !f[1], f[2], !f[2], f[0], !f[0], f[0] | f[2],
           !f[0] & !f[2], 1'b0, 1'b1};
      return t[c];
   endfunction : cond_ok
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      for (int c = 0; c < 16; c++) begin
         for (int f = 0; f < 16; f++) begin
            run({4'h6, c[3:0], 8'h06}, 16'h0, 16'h0, 32'h100, {1'b1, f[3:0]}, 0, 0);
            `CHK(rd_v[`SBD_ST_TAKEN], cond_ok(c[3:0], f[3:0]))
            `CHK(npc, cond_ok(c[3:0], f[3:0]) ? 32'h108 : 32'h102)
            `CHK(fl, {1'b1, f[3:0]})
         end
      end
      run(16'h6600, 16'hFFF0, 16'h0, 32'h1000, 5'h00, 0, 0);
      `CHK(npc, 32'h0000_0FF2)
      run(16'h60FF, 16'h0001, 16'h0002, 32'h2000, 5'h00, 0, 0);
      `CHK(npc, 32'h0001_2004)
      run(16'h6080, 16'h0, 16'h0, 32'h3000, 5'h00, 0, 0);
      `CHK(npc, 32'h0000_2F82)
      ops(16'hE1D0, 0, 32'h4000, 0, 5'h00, 32'h8000, 5'h0A, 0);
      ops(16'hE0D8, 0, 32'h8001, 0, 5'h02, 32'hC000, 5'h19, 0);
      ops(16'hE1F8, 0, 32'h0001, 0, 5'h00, 32'h0002, 5'h00, 0);
      ops(16'hE1F9, 0, 32'h8000, 0, 5'h00, 32'h0000, 5'h17, 0);
      ops(16'hE1C8, 0, 32'h1234, 0, 5'h15, 32'h1234, 5'h15, 1);
      ops(16'hE1FA, 0, 32'h1234, 0, 5'h15, 32'h1234, 5'h15, 1);
      ops(16'h0140, 0, 32'h2, 33, 5'h1F, 32'h0, 5'h1B, 0);
      ops(16'h0850, 16'h000F, 32'h7F, 0, 5'h00, 32'hFF, 5'h04, 0);
      ops(16'h0150, 0, 32'h01, 8, 5'h1B, 32'h00, 5'h1B, 0);
      ops(16'h0148, 0, 32'h5A, 1, 5'h0B, 32'h5A, 5'h0B, 1);
      ops(16'h087C, 16'h1, 32'h5A, 0, 5'h0B, 32'h5A, 5'h0B, 1);
      rd(8'h34);
      `CHK(resp, `SBD_RESP_SLVERR)
      `CHK(rd_v, 32'h0)
      wr(8'h34, 32'h1);
      `CHK(resp, `SBD_RESP_SLVERR)
      print_verdict();
   end
endmodule : tb_shift_branch_bit_change_decode
